// file: hw/rs232_line_port.sv
// Serial remote-control port with modem line gating and flow control
`default_nettype none
module rs232_line_port
  import rs232_port_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       rxd_in,
  input  wire logic       dtr_in,
  input  wire logic       rts_in,
  input  wire logic       port_en_in,
  input  wire logic [1:0] baud_sel_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       rx_ready_in,
  output logic            txd_out,
  output logic            dsr_out,
  output logic            cts_out,
  output logic            tx_ready_out,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_eol_out,
  output logic            rx_overrun_out,
  output logic            rx_frame_err_out,
  output logic            line_abort_out
);
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

  logic                   rst_meta, rst_b;
  line_in_t               pins_raw, line_ok, next_line_ok;
  logic [SYNC_STAGES-1:0] sync [3];
  logic [CYC_W-1:0]       bit_cyc;
  logic                   char_valid, frame_err;
  logic [7:0]             char_data;

  // Reset release through two flip-flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_b    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_b    <= rst_meta;
    end
  end

  // Three-stage pin synchronisers, change accepted when stages two and three agree
  assign pins_raw = '{dtr: dtr_in, rts: rts_in, rxd: rxd_in};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_comb begin
      next_line_ok[i] = (sync[i][1] == sync[i][2]) ? sync[i][2] : line_ok[i];
    end
    always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
        sync[i]    <= {SYNC_STAGES{i == 0}}; // Stages start at the line's idle level
        line_ok[i] <= (i == 0) ? 1'b1 : 1'b0; // Line idles high, modem lines off
      end else begin
        sync[i]    <= {sync[i][1:0], pins_raw[i]};
        line_ok[i] <= next_line_ok[i];
      end
    end
  end

  // Bit period from the selected rate
  always_comb begin
    unique case (baud_sel_in)
      SEL_9600:   bit_cyc = BIT_CYC_9600;
      SEL_19200:  bit_cyc = BIT_CYC_19200;
      SEL_57600:  bit_cyc = BIT_CYC_57600;
      SEL_115200: bit_cyc = BIT_CYC_115200;
    endcase
  end

  rs232_rx_frame rs232_rx_frame_i (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b),
    .rxd_in         (line_ok.rxd),
    .bit_cyc_in     (bit_cyc),
    .char_valid_out (char_valid),
    .char_data_out  (char_data),
    .frame_err_out  (frame_err)
  );

  // Receive slot, gating and clear-to-send
  logic     dtr_prev, next_full, next_overrun, next_abort, next_cts, next_ferr;
  rx_char_t slot, next_slot;
  always_comb begin
    next_full    = rx_valid_out && !rx_ready_in;
    next_slot    = slot;
    next_overrun = 1'b0;
    next_ferr    = frame_err && line_ok.dtr && port_en_in;
    next_abort   = dtr_prev && !line_ok.dtr;
    if (next_abort) begin
      next_full = 1'b0;
    end else if (char_valid && line_ok.dtr && port_en_in) begin
      if (next_full) begin
        next_overrun = 1'b1;
      end else begin
        next_full = 1'b1;
        next_slot = '{data: char_data, eol: char_data == CHAR_CR || char_data == CHAR_LF};
      end
    end
    next_cts = port_en_in && !next_full;
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      dtr_prev         <= 1'b0;
      rx_valid_out     <= 1'b0;
      slot             <= '0;
      rx_overrun_out   <= 1'b0;
      rx_frame_err_out <= 1'b0;
      line_abort_out   <= 1'b0;
      cts_out          <= 1'b0;
      dsr_out          <= 1'b0;
    end else begin
      dtr_prev         <= line_ok.dtr;
      rx_valid_out     <= next_full;
      slot             <= next_slot;
      rx_overrun_out   <= next_overrun;
      rx_frame_err_out <= next_ferr;
      line_abort_out   <= next_abort;
      cts_out          <= next_cts;
      dsr_out          <= port_en_in;
    end
  end
  assign rx_data_out = slot.data;
  assign rx_eol_out  = slot.eol;

  // Transmitter with one-character hold
  tx_state_t        tx_state, next_tx_state;
  logic [CYC_W-1:0] tx_cnt, next_tx_cnt;
  logic [2:0]       tx_bits, next_tx_bits;
  logic [7:0]       tx_hold, next_tx_hold, tx_shift, next_tx_shift;
  logic             tx_full, next_tx_full, next_txd;
  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt   = tx_cnt;
    next_tx_bits  = tx_bits;
    next_tx_hold  = tx_hold;
    next_tx_shift = tx_shift;
    next_tx_full  = tx_full;
    next_txd      = txd_out;
    if (tx_valid_in && !tx_full) begin
      next_tx_full = 1'b1;
      next_tx_hold = tx_data_in;
    end
    if (tx_state != TX_IDLE && tx_cnt != '0) begin
      next_tx_cnt = tx_cnt - 1'b1;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (tx_full && line_ok.rts && port_en_in) begin
            next_tx_state = TX_START;
            next_tx_shift = tx_hold;
            next_tx_full  = 1'b0;
            next_txd      = 1'b0;
            next_tx_cnt   = bit_cyc - 1'b1;
          end
        end
        TX_START, TX_DATA: begin
          next_tx_cnt = bit_cyc - 1'b1;
          if (tx_state == TX_DATA && tx_bits == LAST_BIT) begin
            next_tx_state = TX_STOP;
            next_txd      = 1'b1;
          end else begin
            next_tx_bits  = (tx_state == TX_START) ? 3'h0 : tx_bits + 1'b1;
            next_tx_state = TX_DATA;
            next_txd      = tx_shift[0];
            next_tx_shift = tx_shift >> 1;
          end
        end
        TX_STOP: begin
          next_tx_state = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      tx_state     <= TX_IDLE;
      tx_cnt       <= '0;
      tx_bits      <= 3'h0;
      tx_hold      <= 8'h00;
      tx_shift     <= 8'h00;
      tx_full      <= 1'b0;
      tx_ready_out <= 1'b0;
      txd_out      <= 1'b1;
    end else begin
      tx_state     <= next_tx_state;
      tx_cnt       <= next_tx_cnt;
      tx_bits      <= next_tx_bits;
      tx_hold      <= next_tx_hold;
      tx_shift     <= next_tx_shift;
      tx_full      <= next_tx_full;
      tx_ready_out <= !next_tx_full;
      txd_out      <= next_txd;
    end
  end

  property p_dsr;
    @(posedge clk_in) disable iff (!rst_b) ##1 dsr_out == $past(port_en_in);
  endproperty
  a_dsr: assert property (p_dsr) else $error("dsr does not follow enable");
  property p_cts;
    @(posedge clk_in) disable iff (!rst_b) rx_valid_out |-> !cts_out;
  endproperty
  a_cts: assert property (p_cts) else $error("cts high while slot full");
  property p_tx_rts;
    @(posedge clk_in) disable iff (!rst_b)
      (tx_state == TX_IDLE && next_tx_state == TX_START) |-> line_ok.rts ##1 !txd_out;
  endproperty
  a_tx_rts: assert property (p_tx_rts) else $error("frame started without rts");
  property p_drop;
    @(posedge clk_in) disable iff (!rst_b)
      (char_valid && !line_ok.dtr && !rx_valid_out) |=> !rx_valid_out;
  endproperty
  a_drop: assert property (p_drop) else $error("char kept without dtr");
  property p_accept;
    @(posedge clk_in) disable iff (!rst_b)
      (char_valid && line_ok.dtr && dtr_prev && port_en_in && !rx_valid_out)
      |=> rx_valid_out && rx_data_out == $past(char_data);
  endproperty
  a_accept: assert property (p_accept) else $error("char lost with dtr");
  property p_abort;
    @(posedge clk_in) disable iff (!rst_b)
      (dtr_prev && !line_ok.dtr) |=> line_abort_out && !rx_valid_out;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort on dtr loss");
  property p_eol;
    @(posedge clk_in) disable iff (!rst_b)
      rx_valid_out |-> rx_eol_out == (rx_data_out == CHAR_CR || rx_data_out == CHAR_LF);
  endproperty
  a_eol: assert property (p_eol) else $error("line end flag wrong");
  property p_idle_mark;
    @(posedge clk_in) disable iff (!rst_b)
      $fell(txd_out) |=> !txd_out[*8];
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("start bit too short");
endmodule
`default_nettype wire

// file: hw/rs232_port_pkg.sv
// Constants and types for the serial remote-control port
// Behaviour
// - Receive only while terminal-ready is asserted
// - Drop characters while terminal-ready is deasserted
// - Data-set-ready follows port enable
// - Clear-to-send drops when receive slot full
// - Transmit only while request-to-send asserted; checked at frame start only, a started frame runs to its stop bit
// - Lines end with carriage return or line feed
// - Selectable baud rates, 8 data, no parity, 1 stop
`default_nettype none
package rs232_port_pkg;
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned BAUD_9600   = 9600;
  localparam int unsigned BAUD_19200  = 19200;
  localparam int unsigned BAUD_57600  = 57600;
  localparam int unsigned BAUD_115200 = 115200;
  localparam int unsigned CYC_W       = 12;
  // Clock cycles per bit, rounded to nearest
  localparam logic [CYC_W-1:0] BIT_CYC_9600   = CYC_W'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [CYC_W-1:0] BIT_CYC_19200  = CYC_W'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);
  localparam logic [CYC_W-1:0] BIT_CYC_57600  = CYC_W'((CLK_HZ + BAUD_57600 / 2) / BAUD_57600);
  localparam logic [CYC_W-1:0] BIT_CYC_115200 = CYC_W'((CLK_HZ + BAUD_115200 / 2) / BAUD_115200);
  localparam logic [1:0] SEL_9600   = 2'h0;
  localparam logic [1:0] SEL_19200  = 2'h1;
  localparam logic [1:0] SEL_57600  = 2'h2;
  localparam logic [1:0] SEL_115200 = 2'h3;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [7:0]  CHAR_CR   = 8'h0d;
  localparam logic [7:0]  CHAR_LF   = 8'h0a;
  localparam int unsigned SYNC_STAGES = 3;

  // Pins from the host after filtering
  typedef struct packed {
    logic dtr;
    logic rts;
    logic rxd;
  } line_in_t;

  // One received character with its line-end flag
  typedef struct packed {
    logic [7:0] data;
    logic       eol;
  } rx_char_t;
endpackage
`default_nettype wire

// file: hw/rs232_rx_frame.sv
// Receive framer: start bit, eight data bits, stop bit
`default_nettype none
module rs232_rx_frame
  import rs232_port_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             rxd_in,
  input  wire logic [CYC_W-1:0] bit_cyc_in,
  output logic                  char_valid_out,
  output logic [7:0]            char_data_out,
  output logic                  frame_err_out
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  rx_state_t        state, next_state;
  logic [CYC_W-1:0] cnt, next_cnt;
  logic [2:0]       bits, next_bits;
  logic [7:0]       shift, next_shift;
  logic             next_valid, next_err;
  logic [7:0]       next_data;

  // Bit timing and framing, sampled mid-bit
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_bits  = bits;
    next_shift = shift;
    next_valid = 1'b0;
    next_err   = 1'b0;
    next_data  = char_data_out;
    if (state != RX_IDLE && cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end else begin
      unique case (state)
        RX_IDLE: begin
          if (!rxd_in) begin
            next_state = RX_START;
            next_cnt   = bit_cyc_in >> 1;
          end
        end
        RX_START: begin
          next_cnt   = bit_cyc_in - 1'b1;
          next_bits  = 3'h0;
          next_state = rxd_in ? RX_IDLE : RX_DATA; // Glitch rejected
        end
        RX_DATA: begin
          next_shift = {rxd_in, shift[7:1]};
          next_cnt   = bit_cyc_in - 1'b1;
          if (bits == LAST_BIT) begin
            next_state = RX_STOP;
          end else begin
            next_bits = bits + 1'b1;
          end
        end
        RX_STOP: begin
          next_state = RX_IDLE;
          next_valid = rxd_in;
          next_err   = !rxd_in;
          if (rxd_in) begin
            next_data = shift;
          end
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state          <= RX_IDLE;
      cnt            <= '0;
      bits           <= 3'h0;
      shift          <= 8'h00;
      char_valid_out <= 1'b0;
      frame_err_out  <= 1'b0;
      char_data_out  <= 8'h00;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      bits           <= next_bits;
      shift          <= next_shift;
      char_valid_out <= next_valid;
      frame_err_out  <= next_err;
      char_data_out  <= next_data;
    end
  end

  property p_stop_high;
    @(posedge clk_in) disable iff (!rst_b_in)
      char_valid_out |-> $past(rxd_in) && $past(state) == RX_STOP;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("char without stop bit");
endmodule
`default_nettype wire

// file: test/host_link_model.sv
// Host computer model: serial characters both ways plus modem lines
`default_nettype none
module host_link_model
  import rs232_port_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic [CYC_W-1:0] bit_cyc_in,
  input  wire logic             cts_in,
  input  wire logic             txd_in,
  input  wire logic             dsr_in,
  output logic                  rxd_out,
  output logic                  dtr_out,
  output var logic              rts_out,
  output var logic              got_valid_out,
  output var logic [7:0]        got_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dtr_drive;
  logic loop_dsr;
  logic stop_bit = 1'b1;
  logic cts_lost = 1'b0;

  // Terminal-ready from the host, or looped from data-set-ready on a special cable
  assign dtr_out = loop_dsr ? dsr_in : dtr_drive;

  // Lines idle: data high, no controller present
  initial begin
    rxd_out   = 1'b1;
    dtr_drive = 1'b0;
    loop_dsr  = 1'b0;
    rts_out   = 1'b0;
  end

  // Change the modem lines just after a clock edge
  task automatic set_lines(input logic dtr, input logic rts, input logic loop);
    @(posedge clk_in);
    dtr_drive <= dtr;
    rts_out   <= rts;
    loop_dsr  <= loop;
  endtask

  // Stop bit level for following frames; low makes a framing fault
  task automatic set_stop(input logic s);
    stop_bit = s;
  endtask

  // Send one framed character once clear-to-send allows it
  task automatic send_char(input logic [7:0] b);
    logic [9:0] frame;
    int         n;
    frame = {stop_bit, b, 1'b0};
    n = 0;
    while (cts_in !== 1'b1 && n < 50000) begin
      @(posedge clk_in);
      n++;
    end
    if (cts_in !== 1'b1) begin
      cts_lost = 1'b1;
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      rxd_out <= frame[i];
      repeat (bit_cyc_in - 1) @(posedge clk_in);
    end
    rxd_out <= 1'b1; // Back to idle after a low stop bit
  endtask

  // Decode each device frame mid-bit, LSB first; a low stop bit gives no strobe
  initial begin
    got_valid_out = 1'b0;
    got_data_out  = 8'h00;
    forever begin
      @(negedge txd_in);
      repeat (bit_cyc_in / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc_in) @(posedge clk_in);
        got_data_out[i] <= txd_in;
      end
      repeat (bit_cyc_in) @(posedge clk_in);
      got_valid_out <= txd_in;
      @(posedge clk_in);
      got_valid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: test/rs232_line_port_tb.sv
// Self-checking bench for the serial remote-control port
`default_nettype none
module rs232_line_port_tb;
  import rs232_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_in = 1'b0;
  logic             rst_b_in = 1'b0;
  logic             rxd, dtr, rts, port_en, tx_valid, rx_ready, txd, dsr, cts;
  logic             tx_ready, rx_valid, rx_eol, line_abort, got_valid, ovr, ferr;
  logic [1:0]       baud_sel;
  logic [7:0]       tx_data, rx_data, got_data;
  logic [CYC_W-1:0] bit_cyc;
  int               fails = 0;
  int               checks = 0;
  int               ovr_n = 0;
  int               ferr_n = 0;
  int               n;
  logic [8:0]       rx_exp[$];
  logic [7:0]       tx_exp[$];

  always #25 clk_in = ~clk_in;

  // Bit length for the selected rate
  assign bit_cyc = baud_sel == SEL_9600 ? BIT_CYC_9600 : baud_sel == SEL_19200 ? BIT_CYC_19200 :
                   baud_sel == SEL_57600 ? BIT_CYC_57600 : BIT_CYC_115200;

  rs232_line_port rs232_line_port_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .rxd_in(rxd),
    .dtr_in(dtr), .rts_in(rts), .port_en_in(port_en), .baud_sel_in(baud_sel),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .rx_ready_in(rx_ready), .txd_out(txd),
    .dsr_out(dsr), .cts_out(cts), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_eol_out(rx_eol), .rx_overrun_out(ovr), .rx_frame_err_out(ferr),
    .line_abort_out(line_abort));

  host_link_model host_link_model_i (.clk_in(clk_in), .bit_cyc_in(bit_cyc), .cts_in(cts),
    .txd_in(txd), .dsr_in(dsr), .rxd_out(rxd), .dtr_out(dtr), .rts_out(rts),
    .got_valid_out(got_valid), .got_data_out(got_data));

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_for(ref logic sig, input int lim);
    int k;
    k = 0;
    while (sig !== 1'b1 && k < lim) begin
      @(posedge clk_in);
      k++;
    end
    if (sig !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask

  // Host sends a character; kept ones are noted as expected with their line-end flag
  task automatic host_send(input logic [7:0] c, input logic keep);
    if (keep) rx_exp.push_back({c, c == CHAR_CR || c == CHAR_LF});
    host_link_model_i.send_char(c);
    if (host_link_model_i.cts_lost === 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask

  // Hand a byte to the transmitter, held until the ready edge
  task automatic dev_send(input logic [7:0] c);
    int k;
    tx_exp.push_back(c);
    @(posedge clk_in);
    tx_valid <= 1'b1;
    tx_data  <= c;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (tx_ready !== 1'b1 && k < 30000);
    tx_valid <= 1'b0;
    if (tx_ready !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic drain();
    int k;
    k = 0;
    while ((tx_exp.size() > 0 || rx_exp.size() > 0) && k < 30000) begin
      @(posedge clk_in);
      k++;
    end
    if (tx_exp.size() > 0 || rx_exp.size() > 0) begin
      fails++;
      wrap_up();
    end
    repeat (2 * bit_cyc) @(posedge clk_in);
  endtask

  // Compare each consumed character and each frame the host decoded
  always @(posedge clk_in) begin
    if (ovr === 1'b1) ovr_n++;
    if (ferr === 1'b1) ferr_n++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (rx_exp.size() == 0) check({rx_data, rx_eol}, ~{rx_data, rx_eol});
      else check({rx_data, rx_eol}, rx_exp.pop_front());
    end
    if (got_valid === 1'b1) begin
      if (tx_exp.size() == 0) check({1'b1, got_data}, {1'b0, got_data});
      else check({1'b0, got_data}, {1'b0, tx_exp.pop_front()});
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h417430cf));
    port_en  = 1'b0;
    baud_sel = SEL_115200;
    tx_valid = 1'b0;
    tx_data  = 8'h00;
    rx_ready = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    check({7'h00, dsr, cts}, 9'h000);
    port_en <= 1'b1;
    repeat (3) @(posedge clk_in);
    check({7'h00, dsr, cts}, 9'h003);
    // No controller present: the character is dropped
    host_send(8'($urandom), 1'b0);
    host_link_model_i.set_lines(1'b1, 1'b1, 1'b0);
    repeat (10) @(posedge clk_in);
    host_send(8'($urandom), 1'b1);
    host_send(CHAR_CR, 1'b1);
    host_send(8'($urandom), 1'b1);
    host_send(CHAR_LF, 1'b1);
    drain();
    // Slot full: clear-to-send drops and the host waits
    rx_ready <= 1'b0;
    host_send(8'($urandom), 1'b1);
    wait_for(rx_valid, 200);
    check({8'h00, cts}, 9'h000);
    fork
      host_send(8'($urandom), 1'b1);
      begin
        repeat (3 * bit_cyc) @(posedge clk_in);
        rx_ready <= 1'b1;
      end
    join
    drain();
    // Looped cable supplies terminal-ready
    host_link_model_i.set_lines(1'b0, 1'b1, 1'b1);
    repeat (10) @(posedge clk_in);
    host_send(8'($urandom), 1'b1);
    drain();
    // Terminal-ready lost mid-character: abort and drop
    fork
      host_send(8'($urandom), 1'b0);
      begin
        repeat (5 * bit_cyc) @(posedge clk_in);
        host_link_model_i.set_lines(1'b0, 1'b0, 1'b0);
        wait_for(line_abort, 20);
        check({8'h00, line_abort}, 9'h001);
      end
    join
    // Low stop bit with a controller present: one framing pulse, nothing kept
    host_link_model_i.set_lines(1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge clk_in);
    host_link_model_i.set_stop(1'b0);
    host_send(8'($urandom), 1'b0);
    host_link_model_i.set_stop(1'b1);
    repeat (2 * bit_cyc) @(posedge clk_in);
    // Request-to-send low holds the line idle
    dev_send(8'($urandom));
    n = 0;
    repeat (4 * bit_cyc) begin
      @(posedge clk_in);
      if (txd !== 1'b1) n++;
    end
    check(9'(n), 9'h000);
    host_link_model_i.set_lines(1'b1, 1'b1, 1'b0);
    drain();
    // Every rate, back to back at the fastest
    for (int s = 0; s < 4; s++) begin
      baud_sel <= 2'(s);
      repeat (4) @(posedge clk_in);
      dev_send(8'($urandom));
      if (s == 3) dev_send(8'($urandom));
      drain();
    end
    check(9'(tx_exp.size() + rx_exp.size()), 9'h000);
    check(9'(ovr_n), 9'h000);
    check(9'(ferr_n), 9'h001);
    wrap_up();
  end
endmodule
`default_nettype wire
